/* File: core/cvs_pkg.sv */
// shared types and constants for the command value scaling block
package cvs_pkg;

  localparam int CVS_LVL_W  = 16;
  localparam int CVS_GRAD_W = 17;
  localparam int CVS_REF_W  = 16;
  localparam int CVS_CMD_W  = 24;
  localparam int CVS_NUM_W  = 34;
  localparam int CVS_DEN_W  = 16;

  // level units: 0.01 V per lsb on voltage, 0.02 mA per lsb on current
  localparam int CVS_LSB_PER_V  = 100;
  localparam int CVS_LSB_PER_MA = 50;

  // gradient in 0.001 % per V or per mA
  localparam logic [16:0] CVS_GRAD_MIN     = 17'h00001;
  localparam logic [16:0] CVS_GRAD_MAX     = 17'h186A0;
  localparam logic [16:0] CVS_GRAD_DEF_V10 = 17'h02710;
  localparam logic [16:0] CVS_GRAD_DEF_BIP = 17'h02710;
  localparam logic [16:0] CVS_GRAD_DEF_I20 = 17'h01388;
  localparam logic [16:0] CVS_GRAD_DEF_I4  = 17'h0186A;
  localparam logic [16:0] CVS_GRAD_DEF_PRF = 17'h003E8;

  localparam logic signed [15:0] CVS_OFS_V_LIM = 16'sh03E8;
  localparam logic signed [15:0] CVS_OFS_I_LIM = 16'sh03E8;
  localparam logic [15:0]        CVS_IF_V_MAX  = 16'h03E8;
  localparam logic [15:0]        CVS_IF_I_MAX  = 16'h03E8;
  // 3.6 mA on the 4-20 mA loop
  localparam logic signed [15:0] CVS_CB_THRESH = 16'sh00B4;

  localparam logic [2:0] CVS_ERR_NONE  = 3'h0;
  localparam logic [2:0] CVS_ERR_STATE = 3'h1;
  localparam logic [2:0] CVS_ERR_SIG   = 3'h2;
  localparam logic [2:0] CVS_ERR_INV   = 3'h3;
  localparam logic [2:0] CVS_ERR_RANGE = 3'h4;
  localparam logic [2:0] CVS_ERR_ORDER = 3'h5;

  typedef enum logic [2:0] {
    CVS_SIG_V10, CVS_SIG_BIP10, CVS_SIG_I20, CVS_SIG_I4_20, CVS_SIG_PROFILE
  } cvs_sig_t;

  typedef enum logic [2:0] {
    CVS_CM_PQ_OL, CVS_CM_PQ_CL, CVS_CM_POS_OL, CVS_CM_SPEED_CL,
    CVS_CM_POS_CL, CVS_CM_PRES_CL, CVS_CM_PQ, CVS_CM_ALT
  } cvs_mode_t;

  typedef enum logic [1:0] {
    CVS_OP_UNI1, CVS_OP_UNI2, CVS_OP_BIP2, CVS_OP_UNI2_DI
  } cvs_op_t;

  typedef enum logic [1:0] {
    ANALOG_VOLTAGE_INPUT_ONE, ANALOG_CURRENT_INPUT_TWO,
    ANALOG_VOLTAGE_INPUT_THREE, ANALOG_CURRENT_INPUT_FOUR
  } cvs_inp_t;

  typedef struct packed {
    cvs_sig_t                sig;
    logic                    alt_input;
    logic                    invert;
    logic                    cb_en;
    logic [16:0]             gradient;
    logic signed [15:0]      offset;
    logic [15:0]             if_lo;
    logic [15:0]             if_hi;
    logic signed [15:0]      ref_lo;
    logic signed [15:0]      ref_hi;
  } cvs_cfg_t;

  typedef struct packed {
    logic [3:0][15:0] lvl;
  } cvs_adc_t;

  localparam cvs_cfg_t CVS_CFG_RST = '{
    sig: CVS_SIG_V10, alt_input: 1'b0, invert: 1'b0, cb_en: 1'b0,
    gradient: CVS_GRAD_DEF_V10, offset: 16'sh0000,
    if_lo: 16'h0000, if_hi: 16'h03E8,
    ref_lo: 16'sh0000, ref_hi: 16'sh03E8
  };

endpackage : cvs_pkg

/* File: core/cvs_div.sv */
// serial restoring divider for the closed loop interpolation
`timescale 1ns/1ns
module cvs_div #(
  parameter int NUM_W = 34,
  parameter int DEN_W = 16
) (
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             start_in,
  input  wire logic [NUM_W-1:0] num_in,
  input  wire logic [DEN_W-1:0] den_in,
  output logic                  busy_out,
  output logic                  done_out,
  output logic [NUM_W-1:0]      quo_out
);
  localparam int CNT_W = $clog2(NUM_W);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
    logic [DEN_W:0]   rem;
    logic [NUM_W-1:0] quo;
    logic [DEN_W-1:0] den;
  } cvs_div_st_t;

  cvs_div_st_t st_r;
  cvs_div_st_t st_nxt;
  logic [DEN_W+1:0] diff;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    diff = {1'b0, st_r.rem[DEN_W-1:0], st_r.quo[NUM_W-1]}
           - {2'b00, st_r.den};
    if (st_r.busy) begin
      if (!diff[DEN_W+1]) begin
        st_nxt.rem = diff[DEN_W:0];
      end else begin
        st_nxt.rem = {st_r.rem[DEN_W-1:0], st_r.quo[NUM_W-1]};
      end
      st_nxt.quo = {st_r.quo[NUM_W-2:0], ~diff[DEN_W+1]};
      st_nxt.cnt = st_r.cnt - 1'b1;
      if (st_r.cnt == '0) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end else if (start_in) begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt  = CNT_W'(NUM_W - 1);
      st_nxt.rem  = '0;
      st_nxt.quo  = num_in;
      st_nxt.den  = den_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_out = st_r.busy;
  assign done_out = st_r.done;
  assign quo_out  = st_r.quo;

endmodule : cvs_div

/* File: core/cvs_scale.sv */
// command value conditioning: type checks, input select and scaling
`timescale 1ns/1ns
// Operation
// - signal types: 0-10V, +/-10V, 0-20mA, 4-20mA, profile
// - bipolar only in bipolar-capable modes, bipolar operation
// - profile type only in alternating control mode
// - signal type auto-selects matching analogue input
// - optional inversion, only in two open loops
// - cable-break detection enable setting
// - open loop gradient/offset, closed loop point pairs
// - gradient 0.001..100.000 percent per volt/milliamp
// - signal type change reloads default gradient
// - non-default gradient accepted with reduced resolution
// - offset only open loop, within +/-10V or +/-20mA
// - lower interface level within 0..10V or 0..20mA
// - upper interface level within same ranges
// - lower reference must be below upper reference
// - interface and reference set only in closed loop
// - gradient and offset set only in open loop
// - settings change only while controller disabled
module cvs_scale
  import cvs_pkg::*;
(
  input  wire logic                        ref_clk_in,
  input  wire logic                        arst_n_in,
  input  wire cvs_mode_t                   ctrl_mode_in,
  input  wire cvs_op_t                     op_mode_in,
  input  wire logic                        ctrl_disabled_in,
  input  wire logic                        cfg_wr_in,
  input  wire cvs_cfg_t                    cfg_in,
  input  wire cvs_inp_t                    feedback_inp_in,
  input  wire logic                        adc_valid_in,
  input  wire cvs_adc_t                    adc_in,
  input  wire logic signed [CVS_CMD_W-1:0] profile_in,
  output cvs_cfg_t                         cfg_out,
  output cvs_inp_t                         inp_sel_out,
  output logic                             cfg_ack_out,
  output logic [2:0]                       cfg_err_out,
  output logic                             reduced_res_out,
  output logic                             same_inp_out,
  output logic                             cable_break_out,
  output logic                             busy_out,
  output logic                             cmd_valid_out,
  output logic signed [CVS_CMD_W-1:0]      cmd_out
);

  typedef struct packed {
    cvs_cfg_t                    cfg;
    cvs_inp_t                    inp;
    logic                        ack;
    logic [2:0]                  err;
    logic                        red;
    logic                        same;
    logic                        cb;
    logic                        pend;
    logic                        neg;
    logic                        vld;
    logic signed [CVS_CMD_W-1:0] cmd;
  } cvs_st_t;

  cvs_st_t st_r;
  cvs_st_t st_nxt;

  logic                  div_start;
  logic [CVS_NUM_W-1:0]  div_num;
  logic [CVS_DEN_W-1:0]  div_den;
  logic                  div_busy;
  logic                  div_done;
  logic [CVS_NUM_W-1:0]  div_quo;

  function automatic logic is_open(input cvs_mode_t m);
    is_open = (m == CVS_CM_PQ_OL) || (m == CVS_CM_POS_OL) ||
              (m == CVS_CM_PQ);
  endfunction : is_open

  function automatic logic bip_ok(input cvs_mode_t m);
    bip_ok = (m == CVS_CM_PQ_OL) || (m == CVS_CM_POS_OL) ||
             (m == CVS_CM_PQ);
  endfunction : bip_ok

  function automatic logic inv_ok(input cvs_mode_t m);
    inv_ok = (m == CVS_CM_PQ_OL) || (m == CVS_CM_POS_OL);
  endfunction : inv_ok

  function automatic logic is_volt(input cvs_sig_t s);
    is_volt = (s == CVS_SIG_V10) || (s == CVS_SIG_BIP10);
  endfunction : is_volt

  function automatic logic [16:0] grad_def(input cvs_sig_t s);
    case (s)
      CVS_SIG_V10:   grad_def = CVS_GRAD_DEF_V10;
      CVS_SIG_BIP10: grad_def = CVS_GRAD_DEF_BIP;
      CVS_SIG_I20:   grad_def = CVS_GRAD_DEF_I20;
      CVS_SIG_I4_20: grad_def = CVS_GRAD_DEF_I4;
      default:       grad_def = CVS_GRAD_DEF_PRF;
    endcase
  endfunction : grad_def

  function automatic cvs_inp_t auto_inp(input cvs_sig_t s,
                                        input logic     alt);
    if (is_volt(s)) begin
      auto_inp = alt ? ANALOG_VOLTAGE_INPUT_THREE
                     : ANALOG_VOLTAGE_INPUT_ONE;
    end else begin
      auto_inp = alt ? ANALOG_CURRENT_INPUT_FOUR
                     : ANALOG_CURRENT_INPUT_TWO;
    end
  endfunction : auto_inp

  function automatic logic [CVS_NUM_W-1:0] mag_num(
    input logic signed [CVS_NUM_W-1:0] v);
    mag_num = v[CVS_NUM_W-1] ? CVS_NUM_W'(-v) : v;
  endfunction : mag_num

  function automatic logic [2:0] check_cfg(input cvs_cfg_t  c,
                                           input cvs_mode_t m,
                                           input cvs_op_t   op,
                                           input logic      dis);
    logic signed [15:0] lim;
    logic [15:0]        ifmax;
    lim   = is_volt(c.sig) ? CVS_OFS_V_LIM : CVS_OFS_I_LIM;
    ifmax = is_volt(c.sig) ? CVS_IF_V_MAX : CVS_IF_I_MAX;
    if (!dis) begin
      check_cfg = CVS_ERR_STATE;
    end else if (c.sig == CVS_SIG_BIP10 &&
                 !(bip_ok(m) && op == CVS_OP_BIP2)) begin
      check_cfg = CVS_ERR_SIG;
    end else if (c.sig == CVS_SIG_PROFILE && m != CVS_CM_ALT) begin
      check_cfg = CVS_ERR_SIG;
    end else if (c.invert && !inv_ok(m)) begin
      check_cfg = CVS_ERR_INV;
    end else if (is_open(m) &&
                 (c.gradient < CVS_GRAD_MIN ||
                  c.gradient > CVS_GRAD_MAX)) begin
      check_cfg = CVS_ERR_RANGE;
    end else if (is_open(m) &&
                 (c.offset > lim || c.offset < -lim)) begin
      check_cfg = CVS_ERR_RANGE;
    end else if (!is_open(m) &&
                 (c.if_lo > ifmax || c.if_hi > ifmax)) begin
      check_cfg = CVS_ERR_RANGE;
    end else if (!is_open(m) &&
                 (c.ref_lo >= c.ref_hi || c.if_lo == c.if_hi)) begin
      check_cfg = CVS_ERR_ORDER;
    end else begin
      check_cfg = CVS_ERR_NONE;
    end
  endfunction : check_cfg

  // configuration path
  logic [2:0]          wr_err;
  cvs_cfg_t            new_cfg;
  cvs_inp_t            new_inp;

  always_comb begin
    wr_err  = check_cfg(cfg_in, ctrl_mode_in, op_mode_in,
                        ctrl_disabled_in);
    new_cfg = st_r.cfg;
    new_cfg.sig       = cfg_in.sig;
    new_cfg.alt_input = cfg_in.alt_input;
    new_cfg.invert    = cfg_in.invert;
    new_cfg.cb_en     = cfg_in.cb_en;
    // fields that do not belong to the present mode keep old values
    if (is_open(ctrl_mode_in)) begin
      new_cfg.gradient = cfg_in.gradient;
      new_cfg.offset   = cfg_in.offset;
    end else begin
      new_cfg.if_lo  = cfg_in.if_lo;
      new_cfg.if_hi  = cfg_in.if_hi;
      new_cfg.ref_lo = cfg_in.ref_lo;
      new_cfg.ref_hi = cfg_in.ref_hi;
    end
    // a type change overrides any gradient written with it
    if (cfg_in.sig != st_r.cfg.sig) begin
      new_cfg.gradient = grad_def(cfg_in.sig);
    end
    new_inp = auto_inp(cfg_in.sig, cfg_in.alt_input);
  end

  // sample path
  logic signed [15:0]          raw_lvl;
  logic signed [15:0]          lvl;
  logic signed [16:0]          ofs_diff;
  logic signed [35:0]          ol_prod;
  logic signed [35:0]          ol_cmd;
  logic signed [16:0]          if_diff;
  logic signed [16:0]          if_span;
  logic signed [16:0]          ref_span;
  logic signed [CVS_NUM_W-1:0] cl_num;
  logic signed [CVS_CMD_W-1:0] cl_q;

  always_comb begin
    raw_lvl = $signed(adc_in.lvl[st_r.inp]);
    // inversion stays inert if the mode left the two inverting open loops
    if (st_r.cfg.invert && inv_ok(ctrl_mode_in)) begin
      lvl = -raw_lvl;
    end else begin
      lvl = raw_lvl;
    end
    ofs_diff = 17'(lvl) - 17'(st_r.cfg.offset);
    ol_prod  = 36'(ofs_diff) * $signed({19'h00000, st_r.cfg.gradient});
    if (is_volt(st_r.cfg.sig)) begin
      ol_cmd = ol_prod / 36'sd100;
    end else begin
      ol_cmd = ol_prod / 36'sd50;
    end
    if_diff  = 17'(lvl) - $signed({1'b0, st_r.cfg.if_lo});
    if_span  = $signed({1'b0, st_r.cfg.if_hi})
               - $signed({1'b0, st_r.cfg.if_lo});
    ref_span = 17'(st_r.cfg.ref_hi) - 17'(st_r.cfg.ref_lo);
    cl_num   = CVS_NUM_W'(if_diff) * CVS_NUM_W'(ref_span);
    div_num  = mag_num(cl_num);
    div_den  = if_span[16] ? CVS_DEN_W'(-if_span)
                           : CVS_DEN_W'(if_span);
    cl_q     = st_r.neg ? -$signed(CVS_CMD_W'(div_quo))
                        : $signed(CVS_CMD_W'(div_quo));
  end

  // a closed loop sample is dropped while the divider is still busy
  assign div_start = adc_valid_in && !is_open(ctrl_mode_in) &&
                     st_r.cfg.sig != CVS_SIG_PROFILE &&
                     !st_r.pend && !div_busy;

  cvs_div #(
    .NUM_W (CVS_NUM_W),
    .DEN_W (CVS_DEN_W)
  ) u_div (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .start_in   (div_start),
    .num_in     (div_num),
    .den_in     (div_den),
    .busy_out   (div_busy),
    .done_out   (div_done),
    .quo_out    (div_quo)
  );

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = cfg_wr_in;
    st_nxt.vld = 1'b0;
    if (cfg_wr_in) begin
      st_nxt.err = wr_err;
      if (wr_err == CVS_ERR_NONE) begin
        st_nxt.cfg = new_cfg;
        st_nxt.inp = new_inp;
      end
    end
    st_nxt.red  = st_nxt.cfg.gradient != grad_def(st_nxt.cfg.sig);
    st_nxt.same = st_nxt.inp == feedback_inp_in;
    if (adc_valid_in) begin
      // only the 4-20 mA loop has a live-zero to judge a break by
      st_nxt.cb = st_r.cfg.cb_en && st_r.cfg.sig == CVS_SIG_I4_20 &&
                  raw_lvl < CVS_CB_THRESH;
      if (st_r.cfg.sig == CVS_SIG_PROFILE) begin
        st_nxt.cmd = profile_in;
        st_nxt.vld = 1'b1;
      end else if (is_open(ctrl_mode_in)) begin
        st_nxt.cmd = CVS_CMD_W'(ol_cmd);
        st_nxt.vld = 1'b1;
      end else if (div_start) begin
        st_nxt.pend = 1'b1;
        st_nxt.neg  = cl_num[CVS_NUM_W-1] ^ if_span[16];
      end
    end
    if (div_done && st_r.pend) begin
      st_nxt.cmd  = CVS_CMD_W'(st_r.cfg.ref_lo) + cl_q;
      st_nxt.vld  = 1'b1;
      st_nxt.pend = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r      <= '0;
      st_r.cfg  <= CVS_CFG_RST;
      st_r.inp  <= ANALOG_VOLTAGE_INPUT_ONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_out         = st_r.cfg;
  assign inp_sel_out     = st_r.inp;
  assign cfg_ack_out     = st_r.ack;
  assign cfg_err_out     = st_r.err;
  assign reduced_res_out = st_r.red;
  assign same_inp_out    = st_r.same;
  assign cable_break_out = st_r.cb;
  assign busy_out        = st_r.pend | div_busy;
  assign cmd_valid_out   = st_r.vld;
  assign cmd_out         = st_r.cmd;

endmodule : cvs_scale

/* File: verification/cvs_src.sv */
// analogue command source model driving the four a/d channels
`timescale 1ns/1ns
module cvs_src
  import cvs_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        req_in,
  input  wire cvs_inp_t    ch_in,
  input  wire logic [15:0] lvl_in,
  output logic             adc_valid_out,
  output cvs_adc_t         adc_out
);
  logic [15:0] junk_r;
  // unused channels change every cycle so a wrong select never matches
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      junk_r        <= 16'h5A5A;
      adc_valid_out <= 1'b0;
      adc_out       <= '0;
    end else begin
      junk_r        <= ~junk_r + 16'h0013;
      adc_valid_out <= req_in;
      for (int i = 0; i < 4; i++) begin
        adc_out.lvl[i] <= (i == int'(ch_in)) ? lvl_in : junk_r;
      end
    end
  end
endmodule : cvs_src

/* File: verification/cvs_scale_properties.sv */
// concurrent checks on the command value scaling ports
`timescale 1ns/1ns
module cvs_scale_properties
  import cvs_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       arst_n_in,
  input wire cvs_mode_t  ctrl_mode_in,
  input wire cvs_op_t    op_mode_in,
  input wire logic       ctrl_disabled_in,
  input wire logic       cfg_wr_in,
  input wire cvs_cfg_t   cfg_in,
  input wire logic       adc_valid_in,
  input wire cvs_cfg_t   cfg_out,
  input wire cvs_inp_t   inp_sel_out,
  input wire logic       cfg_ack_out,
  input wire logic [2:0] cfg_err_out,
  input wire logic       reduced_res_out,
  input wire logic       cable_break_out,
  input wire logic       busy_out,
  input wire logic       cmd_valid_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  function automatic logic ol(cvs_mode_t md);
    return md inside {CVS_CM_PQ_OL, CVS_CM_POS_OL, CVS_CM_PQ};
  endfunction : ol
  function automatic logic [16:0] gdef(cvs_sig_t s);
    case (s)
      CVS_SIG_I20:     return CVS_GRAD_DEF_I20;
      CVS_SIG_I4_20:   return CVS_GRAD_DEF_I4;
      CVS_SIG_PROFILE: return CVS_GRAD_DEF_PRF;
      default:         return CVS_GRAD_DEF_V10;
    endcase
  endfunction : gdef
  logic wr_ok;
  assign wr_ok = cfg_wr_in && ctrl_disabled_in;
  AST_STATE: assert property (cfg_wr_in && !ctrl_disabled_in |=>
    cfg_err_out == CVS_ERR_STATE && $stable(cfg_out))
    else $error("write taken while controller enabled");
  AST_BIP: assert property (wr_ok && cfg_in.sig == CVS_SIG_BIP10 &&
    (op_mode_in != CVS_OP_BIP2 || !ol(ctrl_mode_in))
    |=> cfg_err_out == CVS_ERR_SIG) else $error("bipolar not refused");
  AST_PRF: assert property (wr_ok && cfg_in.sig == CVS_SIG_PROFILE &&
    ctrl_mode_in != CVS_CM_ALT |=> cfg_err_out == CVS_ERR_SIG)
    else $error("profile not refused");
  AST_INV: assert property (wr_ok && cfg_in.sig == CVS_SIG_V10 &&
    cfg_in.invert && !(ctrl_mode_in inside {CVS_CM_PQ_OL, CVS_CM_POS_OL})
    |=> cfg_err_out == CVS_ERR_INV) else $error("inversion not refused");
  AST_INP: assert property (cfg_ack_out && cfg_err_out == 3'h0 &&
    cfg_out.sig != CVS_SIG_PROFILE |-> inp_sel_out == cvs_inp_t'(
    {cfg_out.alt_input, cfg_out.sig inside {CVS_SIG_I20, CVS_SIG_I4_20}}))
    else $error("input select does not match type");
  AST_GDEF: assert property ((wr_ok && cfg_in.sig != cfg_out.sig) ##1
    cfg_err_out == 3'h0 |-> cfg_out.gradient == gdef(cfg_out.sig))
    else $error("gradient not reloaded");
  AST_RRES: assert property (
    reduced_res_out == (cfg_out.gradient != gdef(cfg_out.sig)))
    else $error("reduced resolution flag wrong");
  AST_OLAT: assert property (adc_valid_in && !busy_out &&
    (ol(ctrl_mode_in) || cfg_out.sig == CVS_SIG_PROFILE) |=> cmd_valid_out)
    else $error("open loop result late");
  AST_CLAT: assert property (adc_valid_in && !busy_out &&
    !ol(ctrl_mode_in) && cfg_out.sig != CVS_SIG_PROFILE
    |=> busy_out ##35 cmd_valid_out && !busy_out)
    else $error("closed loop result timing");
  AST_CB: assert property (adc_valid_in && !cfg_out.cb_en |=>
    !cable_break_out) else $error("cable break while disabled");
  cover property (busy_out ##1 cmd_valid_out);
  cover property (cfg_ack_out && cfg_err_out == CVS_ERR_ORDER);
  cover property ($rose(cable_break_out));
endmodule : cvs_scale_properties
bind cvs_scale cvs_scale_properties cvs_scale_properties_i (.*);

/* File: verification/tb_cvs_scale.sv */
// self-checking bench for the command value scaling block
`timescale 1ns/1ns
module tb_cvs_scale
  import cvs_pkg::*;
;
  logic                        ref_clk_in = 1'b0;
  logic                        arst_n_in  = 1'b0;
  cvs_mode_t                   mode       = CVS_CM_PQ_OL;
  cvs_op_t                     op         = CVS_OP_BIP2;
  logic                        dis        = 1'b1;
  logic                        wr         = 1'b0;
  logic                        req        = 1'b0;
  cvs_cfg_t                    cin        = CVS_CFG_RST;
  cvs_cfg_t                    m          = CVS_CFG_RST;
  cvs_cfg_t                    c, cfg_o;
  cvs_inp_t                    ch         = ANALOG_VOLTAGE_INPUT_ONE;
  logic [15:0]                 lvl        = 16'h0000;
  logic [15:0]                 lf         = 16'h003E;
  logic signed [CVS_CMD_W-1:0] prof       = '0;
  logic                        valid, ack, rres, same, cbrk, busy, cv;
  cvs_adc_t                    adc;
  cvs_inp_t                    sel;
  logic [2:0]                  err;
  logic signed [CVS_CMD_W-1:0] cmd;
  int                          errors = 0;
  int                          checks = 0;
  int                          cyc    = 0;
  logic [107:0]                cq[$];
  logic [23:0]                 vq[$];
  // feedback kept off the command input until the flag test, then left on input one, the closed loop command input
  cvs_inp_t                    fb = ANALOG_CURRENT_INPUT_FOUR;
  cvs_src cvs_src_i (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .req_in(req), .ch_in(ch), .lvl_in(lvl), .adc_valid_out(valid),
    .adc_out(adc));
  cvs_scale cvs_scale_i (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .ctrl_mode_in(mode), .op_mode_in(op), .ctrl_disabled_in(dis),
    .cfg_wr_in(wr), .cfg_in(cin), .feedback_inp_in(fb),
    .adc_valid_in(valid), .adc_in(adc), .profile_in(prof),
    .cfg_out(cfg_o), .inp_sel_out(sel), .cfg_ack_out(ack),
    .cfg_err_out(err), .reduced_res_out(rres), .same_inp_out(same),
    .cable_break_out(cbrk), .busy_out(busy), .cmd_valid_out(cv),
    .cmd_out(cmd));
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic ol(cvs_mode_t md);
    return md inside {CVS_CM_PQ_OL, CVS_CM_POS_OL, CVS_CM_PQ};
  endfunction : ol
  function automatic logic cur(cvs_cfg_t x);
    // profile counts as current: only voltage types get a voltage input
    return !(x.sig inside {CVS_SIG_V10, CVS_SIG_BIP10});
  endfunction : cur
  function automatic logic [16:0] gdef(cvs_sig_t s);
    case (s)
      CVS_SIG_I20:     return 17'h01388;
      CVS_SIG_I4_20:   return 17'h0186A;
      CVS_SIG_PROFILE: return 17'h003E8;
      default:         return 17'h02710;
    endcase
  endfunction : gdef
  task automatic chk(logic [127:0] got, logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic wcfg(cvs_mode_t md, cvs_cfg_t x, logic [2:0] e);
    cvs_cfg_t n;
    @(posedge ref_clk_in);
    mode <= md;
    cin  <= x;
    wr   <= 1'b1;
    n = x;
    if (ol(md)) begin
      {n.if_lo, n.if_hi, n.ref_lo, n.ref_hi} =
        {m.if_lo, m.if_hi, m.ref_lo, m.ref_hi};
    end else begin
      {n.gradient, n.offset} = {m.gradient, m.offset};
    end
    if (n.sig != m.sig) n.gradient = gdef(n.sig);
    if (e == 3'h0) m = n;
    cq.push_back({e, cvs_inp_t'({m.alt_input, cur(m)}), m});
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask : wcfg
  task automatic samp(logic [15:0] l, logic note);
    longint x, v;
    logic [23:0] p;
    lf = lfsr(lf);
    p = {lf, lf[7:0]};
    @(posedge ref_clk_in);
    lvl  <= l;
    ch   <= cvs_inp_t'({m.alt_input, cur(m)});
    prof <= p;
    req  <= 1'b1;
    x = longint'($signed(l));
    if (m.invert && mode inside {CVS_CM_PQ_OL, CVS_CM_POS_OL}) x = -x;
    if (m.sig == CVS_SIG_PROFILE) v = longint'($signed(p));
    else if (ol(mode)) v = (x - longint'(m.offset)) * longint'(m.gradient)
      / (cur(m) ? 50 : 100);
    else v = longint'(m.ref_lo) + (x - longint'(m.if_lo)) *
      (longint'(m.ref_hi) - longint'(m.ref_lo)) /
      (longint'(m.if_hi) - longint'(m.if_lo));
    if (note) vq.push_back(v[23:0]);
    @(posedge ref_clk_in);
    req <= 1'b0;
  endtask : samp
  always @(negedge ref_clk_in) begin
    if (ack === 1'b1) begin
      if (cq.size() == 0) chk(1, 0);
      else chk({err, sel, cfg_o}, cq.pop_front());
    end
    if (cv === 1'b1) begin
      if (vq.size() == 0) chk(1, 0);
      else chk($unsigned(cmd), vq.pop_front());
    end
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    @(negedge ref_clk_in);
    chk({sel, cfg_o}, {ANALOG_VOLTAGE_INPUT_ONE, CVS_CFG_RST});
    c = CVS_CFG_RST;
    c.sig = CVS_SIG_I20;
    dis <= 1'b0;
    wcfg(CVS_CM_PQ_OL, c, CVS_ERR_STATE);
    dis <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      c.sig = cvs_sig_t'(i);
      c.alt_input = lf[0];
      c.ref_hi = 16'sh0010;
      wcfg(CVS_CM_PQ_OL, c, CVS_ERR_NONE);
    end
    c.sig = CVS_SIG_PROFILE;
    wcfg(CVS_CM_PQ_OL, c, CVS_ERR_SIG);
    wcfg(CVS_CM_ALT, c, CVS_ERR_NONE);
    samp(16'h0000, 1'b1);
    c.sig = CVS_SIG_BIP10;
    wcfg(CVS_CM_ALT, c, CVS_ERR_SIG);
    op <= CVS_OP_UNI1;
    wcfg(CVS_CM_PQ, c, CVS_ERR_SIG);
    c.sig = CVS_SIG_V10;
    c.invert = 1'b1;
    wcfg(CVS_CM_PQ, c, CVS_ERR_INV);
    $display("test types done");
    c.sig = CVS_SIG_I20;
    wcfg(CVS_CM_POS_OL, c, CVS_ERR_NONE);
    c.gradient = 17'h00000;
    wcfg(CVS_CM_POS_OL, c, CVS_ERR_RANGE);
    c.gradient = 17'h186A1;
    wcfg(CVS_CM_POS_OL, c, CVS_ERR_RANGE);
    {c.gradient, c.offset} = {CVS_GRAD_MAX, 16'sh03E9};
    wcfg(CVS_CM_POS_OL, c, CVS_ERR_RANGE);
    c.offset = -16'sh03E8;
    wcfg(CVS_CM_POS_OL, c, CVS_ERR_NONE);
    @(negedge ref_clk_in);
    chk(rres, 1'b1);
    repeat (6) begin
      lf = lfsr(lf);
      samp({6'h00, lf[9:0]}, 1'b1);
    end
    c.sig = CVS_SIG_I4_20;
    {c.cb_en, c.invert} = 2'b10;
    wcfg(CVS_CM_POS_OL, c, CVS_ERR_NONE);
    for (int i = 0; i < 2; i++) begin
      samp(i ? 16'h00C8 : 16'h0064, 1'b1);
      fb <= cvs_inp_t'({m.alt_input, cur(m) ^ i[0]});
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(cbrk, i == 0);
      chk(same, i == 0);
    end
    $display("test open loop done");
    c.sig = CVS_SIG_V10;
    {c.cb_en, c.if_lo, c.if_hi} = {1'b0, 16'h03E9, 16'h0384};
    wcfg(CVS_CM_PQ_CL, c, CVS_ERR_RANGE);
    {c.if_lo, c.if_hi} = {16'h0064, 16'h03E9};
    wcfg(CVS_CM_PQ_CL, c, CVS_ERR_RANGE);
    {c.if_hi, c.ref_lo, c.ref_hi} = {16'h0384, 16'sh01F4, 16'sh01F4};
    wcfg(CVS_CM_PQ_CL, c, CVS_ERR_ORDER);
    {c.ref_lo, c.gradient} = {-16'sh07D0, 17'h00005};
    wcfg(CVS_CM_PQ_CL, c, CVS_ERR_NONE);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      samp({6'h00, lf[9:0]}, 1'b1);
      repeat (2) @(negedge ref_clk_in);
      chk(busy, 1'b1);
      if (i == 3) samp(16'h0200, 1'b0);
      repeat (40) @(posedge ref_clk_in);
    end
    $display("test closed loop done");
    if (cq.size() != 0 || vq.size() != 0) chk(1, 0);
    summarize();
  end
endmodule : tb_cvs_scale
